// ===== rtl/sac_adc_ctrl.sv
/*
  successive-approximation converter control: channel select, pin
  configuration, port direction, bit-serial approximation sequence,
  result registers and end-of-conversion pulse, all behind an
  ahb-lite slave.
  assumes: single-slave bus (hready = hreadyout), full-word transfers,
  an external comparator whose output is valid one cycle after the
  ladder tap changes, pins synchronous to hclk.
*/
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps

module sac_adc_ctrl #(
  parameter int SAMPLE_CYCLES_P = sac_pkg::SAMPLE_CYCLES,
  parameter int NUM_PINS        = 8
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                comp_ge,
  output logic                     sample_en,
  output logic [9:0]               tap_code,
  output logic [2:0]               analog_channel,
  output logic                     channel_valid,
  output logic                     comparator_power,
  output logic                     conversion_done_irq,
  input  wire logic [NUM_PINS-1:0] port2_pin_in,
  output logic [NUM_PINS-1:0]      port2_pin_out,
  output logic [NUM_PINS-1:0]      port2_pin_oe,
  output logic [NUM_PINS-1:0]      analog_pin_mask
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_PINS-1:0] digital_mask(input logic [4:0] cfg);
    logic [NUM_PINS-1:0] m;
    m = '0;
    if (cfg == sac_pkg::PIN_CFG_ALL_B || cfg >= sac_pkg::PIN_CFG_ALL_A) begin
      m = '1;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (i < int'(cfg)) begin
          m[i] = 1'b1;
        end
      end
    end
    return m;
  endfunction

  function automatic logic idx_is(input logic [19:0] idx, input logic [19:0] want);
    return idx == want;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0]          channel_sel_r;
  logic [4:0]          pin_config_r;
  logic [7:0]          port2_dir_r;
  logic [7:0]          mode_r;
  logic [7:0]          periph_en_r;
  logic [7:0]          port2_latch_r;
  logic [9:0]          result_r;
  logic [31:0]         hrdata_r;
  logic                wr_ph_r;
  logic                rd_ph_r;
  logic [19:0]         ph_idx_r;
  logic                conv_done_r;
  sac_pkg::sac_state_e state_r;
  logic [15:0]         samp_cnt_r;
  logic [9:0]          sar_r;
  logic [3:0]          bit_idx_r;

  logic                addr_ok;
  logic                accept;
  logic                wr_en;
  logic                ch_wr;
  logic                conv_gate;
  logic                start_bit;
  logic                busy;
  logic [NUM_PINS-1:0] dig_mask;
  logic [NUM_PINS-1:0] port_read;

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  assign addr_ok   = (haddr[31:22] == 10'h000) && (haddr[1:0] == 2'b00);
  assign accept    = hsel && htrans[1] && hready;
  assign wr_en     = wr_ph_r;
  assign hreadyout = !rd_ph_r;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_r  <= 1'b0;
      ph_idx_r <= 20'h00000;
    end else if (accept) begin
      wr_ph_r  <= hwrite && addr_ok;
      ph_idx_r <= haddr[21:2];
    end else begin
      wr_ph_r  <= 1'b0;
    end
  end

  // reads take one wait state so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_ph_r <= 1'b0;
    end else begin
      rd_ph_r <= accept && !hwrite;
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_ph_r) begin
      hrdata_r <= 32'h0000_0000;
      if (idx_is(ph_idx_r, sac_pkg::IDX_CHANNEL_SEL)) begin
        hrdata_r[7:0] <= channel_sel_r;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_PIN_CONFIG)) begin
        hrdata_r[4:0] <= pin_config_r;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_PORT2_DIR)) begin
        hrdata_r[7:0] <= port2_dir_r;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_MODE)) begin
        hrdata_r[7:0] <= mode_r;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_PERIPH_EN)) begin
        hrdata_r[7:0] <= periph_en_r;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_PORT2_DATA)) begin
        hrdata_r[NUM_PINS-1:0] <= port_read;
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_WIDE_RESULT)) begin
        hrdata_r[15:0] <= {result_r, {sac_pkg::RESULT_PAD{1'b0}}};
      end
      if (idx_is(ph_idx_r, sac_pkg::IDX_NARROW_RESLT)) begin
        hrdata_r[7:0] <= result_r[9:2];
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  assign ch_wr = wr_en && idx_is(ph_idx_r, sac_pkg::IDX_CHANNEL_SEL);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      channel_sel_r <= sac_pkg::RST_CHANNEL_SEL;
    end else if (ch_wr) begin
      // bits three to six held zero
      channel_sel_r <= hwdata[7:0] & sac_pkg::CH_WRITE_MASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_config_r <= sac_pkg::RST_PIN_CONFIG;
    end else if (wr_en && idx_is(ph_idx_r, sac_pkg::IDX_PIN_CONFIG)) begin
      pin_config_r <= hwdata[4:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port2_dir_r <= sac_pkg::RST_PORT2_DIR;
    end else if (wr_en && idx_is(ph_idx_r, sac_pkg::IDX_PORT2_DIR)) begin
      port2_dir_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port2_latch_r <= sac_pkg::RST_PORT2_LATCH;
    end else if (wr_en && idx_is(ph_idx_r, sac_pkg::IDX_PORT2_DATA)) begin
      port2_latch_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= sac_pkg::RST_MODE;
    end else if (wr_en && idx_is(ph_idx_r, sac_pkg::IDX_MODE)) begin
      mode_r <= hwdata[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      periph_en_r <= sac_pkg::RST_PERIPH_EN;
    end else if (wr_en && idx_is(ph_idx_r, sac_pkg::IDX_PERIPH_EN)) begin
      periph_en_r <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // pins and channel routing
  // ----------------------------------------------------------------
  // lowest n pins digital
  assign dig_mask        = digital_mask(pin_config_r);
  assign analog_pin_mask = ~dig_mask;

  // output buffer on for direction zero
  assign port2_pin_out = port2_latch_r[NUM_PINS-1:0];
  assign port2_pin_oe  = ~port2_dir_r[NUM_PINS-1:0] & dig_mask;

  genvar g;
  generate
    for (g = 0; g < NUM_PINS; g++) begin : g_port_read
      assign port_read[g] = !dig_mask[g] ? 1'b0 :
                            (port2_dir_r[g] ? port2_pin_in[g] : port2_latch_r[g]);
    end
  endgenerate

  // three-bit channel, top bit gates inputs 0 and 1
  assign analog_channel = channel_sel_r[2:0];
  assign channel_valid  = !(channel_sel_r[sac_pkg::CH_SRC_BIT] && (channel_sel_r[2:1] == 2'b00));

  assign comparator_power = mode_r[sac_pkg::MODE_CMP_EN_BIT];

  assign conv_gate = periph_en_r[sac_pkg::PER_CLK_GATE_BIT];
  assign start_bit = mode_r[sac_pkg::MODE_START_BIT];
  assign busy      = (state_r != sac_pkg::SAC_IDLE);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= sac_pkg::SAC_IDLE;
    end else if (conv_gate) begin
      if (!start_bit) begin
        state_r <= sac_pkg::SAC_IDLE;
      end else if (ch_wr) begin
        state_r <= sac_pkg::SAC_SAMPLE;
      end else begin
        case (state_r)
          sac_pkg::SAC_IDLE: begin
            state_r <= sac_pkg::SAC_SAMPLE;
          end
          sac_pkg::SAC_SAMPLE: begin
            if (samp_cnt_r == 16'(SAMPLE_CYCLES_P - 1)) begin
              state_r <= sac_pkg::SAC_SET;
            end
          end
          sac_pkg::SAC_SET: begin
            state_r <= sac_pkg::SAC_CMP;
          end
          sac_pkg::SAC_CMP: begin
            if (bit_idx_r == 4'h0) begin
              state_r <= sac_pkg::SAC_DONE;
            end else begin
              state_r <= sac_pkg::SAC_SET;
            end
          end
          sac_pkg::SAC_DONE: begin
            state_r <= sac_pkg::SAC_SAMPLE;
          end
          default: begin
            state_r <= sac_pkg::SAC_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_cnt_r <= 16'h0000;
    end else if (conv_gate) begin
      if (state_r == sac_pkg::SAC_SAMPLE && !ch_wr) begin
        samp_cnt_r <= samp_cnt_r + 16'h0001;
      end else begin
        samp_cnt_r <= 16'h0000;
      end
    end
  end

  // trial bit then keep or clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sar_r     <= 10'h000;
      bit_idx_r <= 4'h0;
    end else if (conv_gate) begin
      case (state_r)
        sac_pkg::SAC_SAMPLE: begin
          sar_r     <= 10'h000;
          bit_idx_r <= 4'(sac_pkg::RESULT_BITS - 1);
        end
        sac_pkg::SAC_SET: begin
          sar_r[bit_idx_r] <= 1'b1;
        end
        sac_pkg::SAC_CMP: begin
          if (!comp_ge) begin
            sar_r[bit_idx_r] <= 1'b0;
          end
          if (bit_idx_r != 4'h0) begin
            bit_idx_r <= bit_idx_r - 4'h1;
          end
        end
        default: begin
          bit_idx_r <= bit_idx_r;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= sac_pkg::RST_RESULT;
    end else if (conv_gate && start_bit && !ch_wr && state_r == sac_pkg::SAC_DONE) begin
      result_r <= sar_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_done_r <= 1'b0;
    end else begin
      conv_done_r <= conv_gate && start_bit && !ch_wr && state_r == sac_pkg::SAC_DONE;
    end
  end

  // ----------------------------------------------------------------
  // analog side
  // ----------------------------------------------------------------
  assign sample_en           = (state_r == sac_pkg::SAC_SAMPLE);
  assign tap_code            = sar_r;
  assign conversion_done_irq = conv_done_r;

endmodule

// ===== rtl/sac_pkg.sv
/*
  constants for the converter channel and sequence control block:
  register indices, reset values, field positions, timing.
  assumes: 10 MHz hclk, word-per-register bus map (byte address = 4 x index).
*/
package sac_pkg;

  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [19:0] IDX_PIN_CONFIG   = 20'hf0017;
  localparam logic [19:0] IDX_PORT2_DIR    = 20'hfff22;
  localparam logic [19:0] IDX_CHANNEL_SEL  = 20'hfff31;
  localparam logic [19:0] IDX_MODE         = 20'hfff30;
  localparam logic [19:0] IDX_WIDE_RESULT  = 20'hfff1e;
  localparam logic [19:0] IDX_NARROW_RESLT = 20'hfff1f;
  localparam logic [19:0] IDX_PERIPH_EN    = 20'hf00f0;
  localparam logic [19:0] IDX_PORT2_DATA   = 20'hfff02;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_CHANNEL_SEL  = 8'h00;
  localparam logic [4:0]  RST_PIN_CONFIG   = 5'h10;
  localparam logic [7:0]  RST_PORT2_DIR    = 8'hff;
  localparam logic [7:0]  RST_MODE         = 8'h00;
  localparam logic [7:0]  RST_PERIPH_EN    = 8'h00;
  localparam logic [7:0]  RST_PORT2_LATCH  = 8'h00;
  localparam logic [9:0]  RST_RESULT       = 10'h000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          MODE_START_BIT   = 7;
  localparam int          MODE_CMP_EN_BIT  = 0;
  localparam int          PER_CLK_GATE_BIT = 5;
  localparam int          CH_SRC_BIT       = 7;
  localparam logic [7:0]  CH_WRITE_MASK    = 8'h87;
  localparam logic [4:0]  PIN_CFG_ALL_A    = 5'h08;
  localparam logic [4:0]  PIN_CFG_ALL_B    = 5'h10;
  localparam int          RESULT_PAD       = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          SAMPLE_TIME_NS   = 1000;
  localparam int          SAMPLE_CYCLES    = (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          RESULT_BITS      = 10;

  // ----------------------------------------------------------------
  // sequencer states, gray along sample-set-compare-done
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SAC_IDLE   = 3'b000,
    SAC_SAMPLE = 3'b001,
    SAC_SET    = 3'b011,
    SAC_CMP    = 3'b010,
    SAC_DONE   = 3'b110
  } sac_state_e;

endpackage

// ===== verification/sac_monitor.sv
/*
  checker on the converter control ports.
  assumes: bound to the top module, hready fed from hreadyout.
*/
`timescale 1ns/10ps
module sac_monitor #(
  parameter int SAMPLE_CYCLES_P = sac_pkg::SAMPLE_CYCLES,
  parameter int NUM_PINS        = 8
) (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic                sample_en,
  input wire logic [9:0]          tap_code,
  input wire logic                comparator_power,
  input wire logic                conversion_done_irq,
  input wire logic [NUM_PINS-1:0] port2_pin_oe,
  input wire logic [NUM_PINS-1:0] analog_pin_mask
);
  logic [7:0] hi_cnt_r;
  logic [7:0] lo_cnt_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------------------------------
  // sampling and approximation phase counters
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hi_cnt_r <= 8'h00;
    else hi_cnt_r <= sample_en ? hi_cnt_r + 8'h01 : 8'h00;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lo_cnt_r <= 8'h00;
    else if (sample_en) lo_cnt_r <= 8'h00;
    else if (lo_cnt_r != 8'hff) lo_cnt_r <= lo_cnt_r + 8'h01;
  end
  AST_SAMPLE_TIME: assert property ($fell(sample_en) |-> hi_cnt_r == 8'(SAMPLE_CYCLES_P))
    else $error("sampling phase length wrong");
  AST_HOLD_TAP: assert property (sample_en && $past(sample_en) && $past(sample_en, 2) |-> $stable(tap_code))
    else $error("tap moved while sampling");
  AST_FIRST_TAP: assert property ($fell(sample_en) |=> tap_code == 10'h200)
    else $error("first trial tap is not half scale");
  AST_CONV_STEPS: assert property (conversion_done_irq |-> lo_cnt_r inside {[21:22]})
    else $error("done pulse not after ten steps");
  AST_IRQ_PULSE: assert property (conversion_done_irq |=> (!conversion_done_irq) [*8])
    else $error("done pulse too long or too close");
  AST_RESTART: assert property (conversion_done_irq |-> ##[0:2] sample_en)
    else $error("no automatic restart");
  AST_POWER_FIRST: assert property ($rose(sample_en) |-> comparator_power)
    else $error("sampling without comparator power");
  AST_OE_DIGITAL: assert property ((port2_pin_oe & analog_pin_mask) == '0)
    else $error("analog pin driven");
  AST_RESET_PINS: assert property ($rose(hresetn) |-> analog_pin_mask == '0 && port2_pin_oe == '0)
    else $error("pins not digital inputs after reset");
  AST_READ_WAIT: assert property (hsel && htrans[1] && !hwrite && hready |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  AST_WRITE_NOWAIT: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
    else $error("write stalled");
  AST_OKAY: assert property (!hresp)
    else $error("response not okay");
endmodule

bind sac_adc_ctrl sac_monitor #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P), .NUM_PINS(NUM_PINS)) i_sac_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .sample_en(sample_en), .tap_code(tap_code),
  .comparator_power(comparator_power), .conversion_done_irq(conversion_done_irq),
  .port2_pin_oe(port2_pin_oe), .analog_pin_mask(analog_pin_mask));

// ===== verification/sac_analog_model.sv
/*
  sample-hold, ladder tap and comparator model.
  assumes: vin holds one code per analog input, hclk from the bench.
*/
`timescale 1ns/10ps
module sac_analog_model (
  input  wire logic       hclk,
  input  wire logic       sample_en,
  input  wire logic       comparator_power,
  input  wire logic [2:0] analog_channel,
  input  wire logic [9:0] tap_code,
  input  wire logic [9:0] vin [8],
  output logic            comp_ge
);
  logic [9:0] held_r = 10'h000;
  logic       junk_r = 1'b0;
  always_ff @(posedge hclk) begin
    if (sample_en) held_r <= vin[analog_channel];
  end
  always_ff @(posedge hclk) junk_r <= ~junk_r;
  assign comp_ge = comparator_power ? (held_r >= tap_code) : junk_r;
endmodule

// ===== verification/test_sac_adc_ctrl.sv
/*
  self-checking bench: registers, pins, conversions, abort, stop, gating.
  assumes: package compiled first, checker bound, analog model beside.
*/
`timescale 1ns/10ps
module test_sac_adc_ctrl;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  port2_pin_in = 8'h00;
  logic        hreadyout, hresp, comp_ge, sample_en, channel_valid, comparator_power, conversion_done_irq;
  logic [31:0] hrdata;
  logic [9:0]  tap_code;
  logic [2:0]  analog_channel;
  logic [7:0]  port2_pin_out, port2_pin_oe, analog_pin_mask, mask, dir;
  logic [9:0]  vin [8];
  logic [31:0] rnd = 32'h00016c52;
  logic [31:0] exp_q [$];
  logic        rd_ph = 1'b0;
  int          mismatches = 0;
  int          check_count = 0;
  always #50 hclk = ~hclk;
  sac_adc_ctrl #(.SAMPLE_CYCLES_P(4)) i_sac_adc_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .comp_ge(comp_ge), .sample_en(sample_en),
    .tap_code(tap_code), .analog_channel(analog_channel), .channel_valid(channel_valid),
    .comparator_power(comparator_power), .conversion_done_irq(conversion_done_irq),
    .port2_pin_in(port2_pin_in), .port2_pin_out(port2_pin_out), .port2_pin_oe(port2_pin_oe),
    .analog_pin_mask(analog_pin_mask));
  sac_analog_model i_sac_analog_model (.hclk(hclk), .sample_en(sample_en), .comparator_power(comparator_power),
    .analog_channel(analog_channel), .tap_code(tap_code), .vin(vin), .comp_ge(comp_ge));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [19:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {10'h000, idx, 2'h0};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [19:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
  endtask
  task automatic rd(input logic [19:0] idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask
  // irq expected after more than lo cycles and no later than hi; lo == hi means none
  task automatic wait_irq(input int lo, input int hi);
    int n;
    n = 0;
    while (n < hi && conversion_done_irq !== 1'b1) begin
      @(negedge hclk);
      n++;
    end
    chk((lo == hi) ? (conversion_done_irq !== 1'b1) : (conversion_done_irq === 1'b1 && n > lo), 32'h1);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // read results taken off the queue as each read data phase ends
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
    if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      vin[i] = rnd[9:0];
    end
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    rd(sac_pkg::IDX_PIN_CONFIG, 32'h10);
    rd(sac_pkg::IDX_PORT2_DIR, 32'hff);
    rd(sac_pkg::IDX_CHANNEL_SEL, 32'h0);
    rd(sac_pkg::IDX_WIDE_RESULT, 32'h0);
    rd(sac_pkg::IDX_NARROW_RESLT, 32'h0);
    rd(20'h00123, 32'h0);
    $display("test reset done");
    for (int n = 0; n <= 16; n++) begin
      if (n > 8 && n < 16) continue;
      rnd = lfsr(rnd);
      mask = 8'hff << n;
      dir = rnd[7:0] | mask;
      port2_pin_in <= rnd[15:8];
      wr(sac_pkg::IDX_PIN_CONFIG, 32'(n));
      wr(sac_pkg::IDX_PORT2_DIR, {24'h0, dir});
      wr(sac_pkg::IDX_PORT2_DATA, {24'h0, rnd[23:16]});
      @(negedge hclk);
      chk(analog_pin_mask, mask);
      chk(port2_pin_oe, {24'h0, ~dir & ~mask});
      chk(port2_pin_out, rnd[23:16]);
      rd(sac_pkg::IDX_PORT2_DATA, {24'h0, ~mask & ((dir & rnd[15:8]) | (~dir & rnd[23:16]))});
    end
    $display("test pins done");
    wr(sac_pkg::IDX_PIN_CONFIG, 32'h0);
    wr(sac_pkg::IDX_PORT2_DIR, 32'hff);
    wr(sac_pkg::IDX_CHANNEL_SEL, 32'h87);
    rd(sac_pkg::IDX_CHANNEL_SEL, 32'h87);
    @(negedge hclk);
    chk(analog_channel, 32'h7);
    chk(channel_valid, 32'h1);
    wr(sac_pkg::IDX_CHANNEL_SEL, 32'h81);
    @(negedge hclk);
    chk(channel_valid, 32'h0);
    $display("test channel done");
    wr(sac_pkg::IDX_PERIPH_EN, 32'h20);
    wr(sac_pkg::IDX_MODE, 32'h01);
    @(negedge hclk);
    chk(comparator_power, 32'h1);
    repeat (10) @(posedge hclk);
    wr(sac_pkg::IDX_MODE, 32'h81);
    for (int c = 0; c < 8; c++) begin
      repeat (10) @(posedge hclk);
      rnd = lfsr(rnd);
      vin[c] <= rnd[9:0];
      wr(sac_pkg::IDX_CHANNEL_SEL, 32'(c));
      wait_irq(20, 40);
      rd(sac_pkg::IDX_WIDE_RESULT, {16'h0, vin[c], 6'h00});
      rd(sac_pkg::IDX_NARROW_RESLT, {24'h0, vin[c][9:2]});
      wait_irq(10, 30);
    end
    $display("test convert done");
    repeat (10) @(posedge hclk);
    wr(sac_pkg::IDX_MODE, 32'h01);
    wait_irq(80, 80);
    rd(sac_pkg::IDX_WIDE_RESULT, {16'h0, vin[7], 6'h00});
    wr(sac_pkg::IDX_PERIPH_EN, 32'h0);
    wr(sac_pkg::IDX_MODE, 32'h81);
    wait_irq(80, 80);
    wr(sac_pkg::IDX_PERIPH_EN, 32'h20);
    wait_irq(0, 40);
    $display("test stop done");
    wrap_up();
  end
endmodule
